// *** include/iscp_defs.svh ***
/*
 * Offsets, field positions, codes, reset values and timing counts of the
 * isolated sensor command port.
 * Assumes an 8-bit register port addressed by 16-bit byte addresses.
 */
`ifndef ISCP_DEFS_SVH
`define ISCP_DEFS_SVH

// Register addresses
`define ISCP_ADDR_REQ 16'h00FC
`define ISCP_ADDR_RD_HI 16'h2602
`define ISCP_ADDR_RD_LO 16'h2603
`define ISCP_ADDR_SEL_C 16'h2709
`define ISCP_ADDR_SEL_AB 16'h270A

// Request register fields
`define ISCP_REQ_CMD_HI 4
`define ISCP_REQ_CMD_LO 2
`define ISCP_REQ_PHASE_HI 1
`define ISCP_REQ_FAULT_BIT 6

// Item select register fields
`define ISCP_SEL_A_LO 0
`define ISCP_SEL_B_LO 4
`define ISCP_SEL_C_LO 0
`define ISCP_REN_LO 3
`define ISCP_CHOP_LO 6

// Command codes
`define ISCP_CMD_NONE 3'h0
`define ISCP_CMD_FUSE 3'h1
`define ISCP_CMD_SENSE 3'h2
`define ISCP_CMD_BAD5 3'h5
`define ISCP_PHASE_NONE 2'h0

// Item codes, select bits 2:1 (bit 0 is don't-care)
`define ISCP_ITEM_TRIM 2'h0
`define ISCP_ITEM_BG 2'h3
`define ISCP_ITEM_TEMP 2'h0
`define ISCP_ITEM_VSUP 2'h1
`define ISCP_ITEM_VER 2'h2

// Reset values and sizes
`define ISCP_RST_BYTE 8'h00
`define ISCP_NUM_PAIRS 3

// Timing counts in sys_clk cycles
`define ISCP_PULSE_DIV 16
`define ISCP_RSP_TIMEOUT 1024

`endif

// *** include/iscp_pkg.sv ***
/*
 * Types of the isolated sensor command port.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package iscp_pkg;

    // Remote read sequencer states, one-hot
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_issue = 3'b010,
        st_wait = 3'b100
    } iscp_state_t;

endpackage : iscp_pkg

`default_nettype wire

// *** rtl/iscp_item_format.sv ***
/*
 * Places a raw remote answer into the 16-bit read buffer layout.
 * Assumes the raw word carries each item right-aligned, a two-byte item
 * as first byte in bits 15:8 and second byte in bits 7:0.
 */
`default_nettype none
`include "iscp_defs.svh"

module iscp_item_format (
    // Request
    input wire logic [2:0] cmd,
    input wire logic [2:0] item,
    // Data
    input wire logic [15:0] raw,
    output logic [15:0] value
);

    // Select bit 0 never takes part in the decode
    always_comb begin
        value = 16'h0000;
        unique case (cmd)
            `ISCP_CMD_FUSE: begin
                if (item[2:1] == `ISCP_ITEM_TRIM) begin
                    value = {7'h00, raw[7], raw[6:0], 1'b0}; // R15 R20
                end else if (item[2:1] == `ISCP_ITEM_BG) begin
                    value = raw; // R16
                end
            end
            `ISCP_CMD_SENSE: begin
                if (item[2:1] == `ISCP_ITEM_TEMP) begin
                    value = {{5{raw[10]}}, raw[10:0]}; // R17
                end else if (item[2:1] == `ISCP_ITEM_VSUP) begin
                    value = {8'h00, raw[7:0]}; // R18
                end else if (item[2:1] == `ISCP_ITEM_VER) begin
                    value = {raw[7:0], 8'h00}; // R18
                end
            end
            default: begin
                value = 16'h0000;
            end
        endcase
    end

endmodule : iscp_item_format

`default_nettype wire

// *** rtl/iscp_pair_link.sv ***
/*
 * One remote sensor pair: pin mode, power pulse drive and a per-frame
 * count-of-ones decimator of the modulator stream.
 * Assumes pulse_tick and frame_rise are one-cycle pulses on sys_clk.
 */
`default_nettype none

module iscp_pair_link #(
    parameter int ACC_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Control
    input wire logic remote_en,
    input wire logic pulse_tick,
    input wire logic frame_rise,
    // Pins
    input wire logic mod_bit,
    output logic pulse_out,
    output logic analog_en,
    // Result
    output logic [ACC_W-1:0] result,
    output logic result_valid
);

    logic [ACC_W-1:0] acc_q;

    // Pins leave analog use while the pair is remote
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            analog_en <= 1'b1;
        end else begin
            analog_en <= ~remote_en; // R02
        end
    end

    // Power pulses run on their own, no software involved
    always_ff @(posedge sys_clk) begin
        if (reset || !remote_en) begin
            pulse_out <= 1'b0;
        end else if (pulse_tick) begin
            pulse_out <= ~pulse_out; // R04
        end
    end

    // Modulator sampled on the pulse rate, dumped once per frame
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc_q <= '0;
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= frame_rise && remote_en; // R03
            if (frame_rise) begin
                result <= acc_q;
                acc_q <= '0;
            end else if (remote_en && pulse_tick && mod_bit) begin
                acc_q <= acc_q + 1'b1; // R04
            end
        end
    end

endmodule : iscp_pair_link

`default_nettype wire

// *** rtl/iscp_top.sv ***
/*
 * Isolated sensor command port: registers, remote read sequencer,
 * three sensor pairs and the compute-engine RAM writer.
 * Assumes an 8-bit register port with one-cycle strobes, a sensor answer
 * link with a valid strobe, and frame_sync synchronous to sys_clk.
 */
`default_nettype none
`include "iscp_defs.svh"

// Contract
// [R01] Up to three remote sensors at once
// [R02] Remote enable turns pair into digital link
// [R03] Decimate each stream, write RAM each frame
// [R04] Pulses and protocol run without software
// [R05] Software programs item select before request
// [R06] Software then writes request with phase
// [R07] Completion clears command, fills read buffer
// [R08] Parity fault flag updated every read
// [R09] Request writes ignored while read busy (a busy write with bit 6 low still clears the fault flag)
// [R10] Software polls command zero before next
// [R11] Software writes request after busy edge
// [R12] Command in bits 4:2, phase 1:0
// [R13] Commands 1,2 valid; 0,5 ignored
// [R14] Phase 1,2,3 picks pair and select
// [R15] Trim byte placed at bits 8:1
// [R16] Bandgap trims fill upper then lower
// [R17] Temperature sign-extended from bit 10
// [R18] Supply low byte, version high byte
// [R19] Parity fault sticky until software clears
// [R20] Select bit 0 is don't-care
module iscp_top #(
    parameter int ACC_W = 16,
    parameter int RAM_AW = 8,
    parameter logic [7:0] RAM_BASE = 8'h00,
    parameter int PULSE_DIV = `ISCP_PULSE_DIV,
    parameter int RSP_TIMEOUT = `ISCP_RSP_TIMEOUT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Frame timing
    input wire logic frame_sync,
    // Sensor pair pins
    input wire logic [2:0] pair_mod_bit,
    output logic [2:0] pair_pulse_out,
    output logic [2:0] pair_analog_en,
    // Auxiliary request to the sensor link
    output logic aux_req_valid,
    output logic [1:0] aux_req_phase,
    output logic [2:0] aux_req_cmd,
    output logic [2:0] aux_req_item,
    // Auxiliary answer from the sensor link
    input wire logic aux_rsp_valid,
    input wire logic [15:0] aux_rsp_data,
    input wire logic aux_rsp_parity,
    // Compute-engine RAM write
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [ACC_W-1:0] ram_wdata
);

    localparam int NP = `ISCP_NUM_PAIRS;
    localparam int TMO_W = $clog2(RSP_TIMEOUT + 1);
    localparam int DIV_W = $clog2(PULSE_DIV + 1);

    iscp_pkg::iscp_state_t state_q;
    logic [2:0] req_cmd_q;
    logic [1:0] req_phase_q;
    logic fault_q;
    logic [2:0] sel_a_q;
    logic [2:0] sel_b_q;
    logic [2:0] sel_c_q;
    logic [2:0] remote_en_q;
    logic [1:0] chop_q;
    logic [15:0] rd_buf_q;
    logic [TMO_W-1:0] tmo_q;
    logic [DIV_W-1:0] div_q;
    logic pulse_tick_q;
    logic frame_sync_q;
    logic frame_rise;
    logic wr_req;
    logic [2:0] wr_cmd;
    logic [1:0] wr_phase;
    logic cmd_valid;
    logic accept;
    logic rsp_take;
    logic tmo_hit;
    logic parity_bad;
    logic [2:0] cur_item;
    logic [15:0] fmt_value;
    logic [NP-1:0] pend_q;
    logic [NP-1:0] res_valid;
    logic [ACC_W-1:0] res_data [NP];
    logic [ACC_W-1:0] res_q [NP];
    logic [1:0] pick;
    logic pick_any;

    // Request decode
    assign wr_req = reg_wr && (reg_addr == `ISCP_ADDR_REQ);
    assign wr_cmd = reg_wdata[`ISCP_REQ_CMD_HI:`ISCP_REQ_CMD_LO]; // R12
    assign wr_phase = reg_wdata[`ISCP_REQ_PHASE_HI:0]; // R12
    assign cmd_valid = (wr_cmd == `ISCP_CMD_FUSE) || (wr_cmd == `ISCP_CMD_SENSE); // R13
    assign accept = wr_req && (state_q == iscp_pkg::st_idle) && cmd_valid // R09
        && (wr_phase != `ISCP_PHASE_NONE) && remote_en_q[wr_phase - 2'd1]; // R14
    assign rsp_take = (state_q == iscp_pkg::st_wait) && aux_rsp_valid;
    assign tmo_hit = (state_q == iscp_pkg::st_wait) && !aux_rsp_valid && (tmo_q == '0);
    assign parity_bad = ^{aux_rsp_data, aux_rsp_parity};
    assign frame_rise = frame_sync && !frame_sync_q;

    // Phase picks the item select field of its pair
    always_comb begin
        unique case (req_phase_q)
            2'h1: cur_item = sel_a_q; // R14
            2'h2: cur_item = sel_b_q; // R14
            2'h3: cur_item = sel_c_q; // R14
            default: cur_item = 3'h0;
        endcase
    end

    iscp_item_format u_fmt (
        .cmd(req_cmd_q),
        .item(cur_item),
        .raw(aux_rsp_data),
        .value(fmt_value)
    );

    // Configuration registers written by software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sel_a_q <= 3'h0;
            sel_b_q <= 3'h0;
            sel_c_q <= 3'h0;
            remote_en_q <= 3'h0;
            chop_q <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == `ISCP_ADDR_SEL_AB) begin
                sel_a_q <= reg_wdata[`ISCP_SEL_A_LO +: 3]; // R05
                sel_b_q <= reg_wdata[`ISCP_SEL_B_LO +: 3]; // R05
            end
            if (reg_addr == `ISCP_ADDR_SEL_C) begin
                sel_c_q <= reg_wdata[`ISCP_SEL_C_LO +: 3]; // R05
                remote_en_q <= reg_wdata[`ISCP_REN_LO +: 3]; // R02
                chop_q <= reg_wdata[`ISCP_CHOP_LO +: 2];
            end
        end
    end

    // Request field and read sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= iscp_pkg::st_idle;
            req_cmd_q <= 3'h0;
            req_phase_q <= 2'h0;
            tmo_q <= '0;
        end else begin
            unique case (state_q)
                iscp_pkg::st_idle: begin
                    if (accept) begin
                        req_cmd_q <= wr_cmd; // R06
                        req_phase_q <= wr_phase;
                        state_q <= iscp_pkg::st_issue;
                    end
                end
                iscp_pkg::st_issue: begin
                    tmo_q <= TMO_W'(RSP_TIMEOUT);
                    state_q <= iscp_pkg::st_wait;
                end
                iscp_pkg::st_wait: begin
                    if (rsp_take || tmo_hit) begin
                        req_cmd_q <= 3'h0; // R07
                        state_q <= iscp_pkg::st_idle;
                    end else begin
                        tmo_q <= tmo_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Read buffer takes the formatted answer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_buf_q <= 16'h0000;
        end else if (rsp_take) begin
            rd_buf_q <= fmt_value; // R07
        end
    end

    // Parity fault: set wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fault_q <= 1'b0;
        end else if ((rsp_take && parity_bad) || tmo_hit) begin
            fault_q <= 1'b1; // R08
        end else if (wr_req && !reg_wdata[`ISCP_REQ_FAULT_BIT]) begin
            fault_q <= 1'b0; // R19
        end
    end

    // One-cycle request to the sensor link
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aux_req_valid <= 1'b0;
            aux_req_phase <= 2'h0;
            aux_req_cmd <= 3'h0;
            aux_req_item <= 3'h0;
        end else begin
            aux_req_valid <= accept; // R04
            if (accept) begin
                aux_req_phase <= wr_phase;
                aux_req_cmd <= wr_cmd;
                unique case (wr_phase)
                    2'h1: aux_req_item <= sel_a_q;
                    2'h2: aux_req_item <= sel_b_q;
                    default: aux_req_item <= sel_c_q;
                endcase
            end
        end
    end

    // Register read data, valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= `ISCP_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ISCP_ADDR_REQ: reg_rdata <= {1'b0, fault_q, 1'b0, req_cmd_q, req_phase_q};
                `ISCP_ADDR_RD_HI: reg_rdata <= rd_buf_q[15:8];
                `ISCP_ADDR_RD_LO: reg_rdata <= rd_buf_q[7:0];
                `ISCP_ADDR_SEL_C: reg_rdata <= {chop_q, remote_en_q, sel_c_q};
                `ISCP_ADDR_SEL_AB: reg_rdata <= {1'b0, sel_b_q, 1'b0, sel_a_q};
                default: reg_rdata <= `ISCP_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `ISCP_RST_BYTE;
        end
    end

    // Pulse rate divider and frame edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_q <= '0;
            pulse_tick_q <= 1'b0;
            frame_sync_q <= 1'b0;
        end else begin
            frame_sync_q <= frame_sync;
            pulse_tick_q <= (div_q == DIV_W'(PULSE_DIV - 1));
            if (div_q == DIV_W'(PULSE_DIV - 1)) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // Three pairs, each with its result held until its RAM slot
    for (genvar k = 0; k < NP; k++) begin : g_pair
        iscp_pair_link #(.ACC_W(ACC_W)) u_link (
            .sys_clk(sys_clk),
            .reset(reset),
            .remote_en(remote_en_q[k]),
            .pulse_tick(pulse_tick_q),
            .frame_rise(frame_rise),
            .mod_bit(pair_mod_bit[k]),
            .pulse_out(pair_pulse_out[k]),
            .analog_en(pair_analog_en[k]),
            .result(res_data[k]),
            .result_valid(res_valid[k])
        ); // R01

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                pend_q[k] <= 1'b0;
                res_q[k] <= '0;
            end else if (res_valid[k]) begin
                pend_q[k] <= 1'b1; // R03
                res_q[k] <= res_data[k];
            end else if (pick_any && (pick == 2'(k))) begin
                pend_q[k] <= 1'b0;
            end
        end
    end

    // Lowest pending channel owns the next access slot
    always_comb begin
        pick = 2'h0;
        pick_any = 1'b0;
        for (int i = NP - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick = 2'(i);
                pick_any = 1'b1;
            end
        end
    end

    // RAM write port
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= '0;
        end else begin
            ram_we <= pick_any; // R03
            ram_addr <= RAM_AW'(RAM_BASE) + RAM_AW'(pick);
            ram_wdata <= res_q[pick];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_done_clears: assert property (rsp_take |=> req_cmd_q == 3'h0 && state_q == iscp_pkg::st_idle) // R07
        else $error("command not cleared at completion");
    a_buf_loads: assert property (rsp_take |=> rd_buf_q == $past(fmt_value)) // R07
        else $error("read buffer not loaded");
    a_busy_ignore: assert property (wr_req && state_q != iscp_pkg::st_idle && !rsp_take && !tmo_hit // R09
        |=> req_cmd_q == $past(req_cmd_q))
        else $error("request write taken while busy");
    a_bad_cmd: assert property (wr_req && state_q == iscp_pkg::st_idle // R13
        && (wr_cmd == `ISCP_CMD_NONE || wr_cmd == `ISCP_CMD_BAD5) |=> state_q == iscp_pkg::st_idle)
        else $error("invalid command started a read");
    a_parity_set: assert property (rsp_take && parity_bad |=> fault_q) // R08
        else $error("parity fault not raised");
    a_fault_sticky: assert property (fault_q && !(wr_req && !reg_wdata[6]) |=> fault_q) // R19
        else $error("parity fault dropped by itself");
    a_req_pulse: assert property (accept |=> aux_req_valid ##1 !aux_req_valid ##1 state_q == iscp_pkg::st_wait) // R04
        else $error("link request not a single pulse");
    a_pin_mode: assert property (##1 pair_analog_en == ~$past(remote_en_q)) // R02
        else $error("pin mode does not follow remote enable");
    a_trim_layout: assert property (req_cmd_q == 3'h1 && cur_item[2:1] == 2'h0 // R15
        |-> fmt_value == {7'h00, aux_rsp_data[7:0], 1'b0})
        else $error("trim byte misplaced");
    a_ram_slot: assert property (res_valid[0] |=> pend_q[0] ##[1:3] ram_we) // R03
        else $error("result not written to RAM");

    c_read_done: cover property (accept ##[2:20] rsp_take);
    c_parity_fault: cover property (rsp_take && parity_bad);
    c_busy_write: cover property (wr_req && state_q == iscp_pkg::st_wait);
    c_three_slots: cover property (ram_we [*3]);

endmodule : iscp_top

`default_nettype wire

// *** sim/iscp_sensor_model.sv ***
/*
 * Behavioural remote sensor answering auxiliary read requests.
 * Assumes requests arrive as one-cycle pulses on sys_clk; the bench sets
 * the answer word, its delay, a parity fault and a mute before each request.
 */
`default_nettype none

module iscp_sensor_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bench control
    input wire logic [15:0] answer_word,
    input wire logic [7:0] answer_delay,
    input wire logic bad_parity,
    input wire logic mute,
    // Link to the port
    input wire logic aux_req_valid,
    output logic aux_rsp_valid,
    output logic [15:0] aux_rsp_data,
    output logic aux_rsp_parity
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy_q;
    logic [7:0] wait_q;

    // One answer per request unless muted, after the set delay; idle data keeps changing
    always_ff @(posedge sys_clk) begin
        aux_rsp_valid <= 1'b0;
        aux_rsp_data <= ~aux_rsp_data;
        aux_rsp_parity <= ~aux_rsp_parity;
        if (reset) begin
            busy_q <= 1'b0;
            wait_q <= 8'h00;
            aux_rsp_data <= 16'h0000;
            aux_rsp_parity <= 1'b0;
        end else if (aux_req_valid) begin
            busy_q <= ~mute;
            wait_q <= answer_delay;
        end else if (busy_q && wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            aux_rsp_valid <= 1'b1;
            aux_rsp_data <= answer_word;
            aux_rsp_parity <= (^answer_word) ^ bad_parity;
        end
    end
endmodule : iscp_sensor_model

`default_nettype wire

// *** sim/tb.sv ***
/*
 * Self-checking bench of the isolated sensor command port.
 * Assumes the design and the sensor model; short pulse and timeout counts.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] RA [6] = '{16'h00FC, 16'h2602, 16'h2603, 16'h2709, 16'h270A, 16'h1234};
    // cmd, phase, select, raw answer, delay, expected buffer
    localparam logic [47:0] TBL [6] = '{
        {3'h1, 2'h1, 3'h0, 16'h00A5, 8'h00, 16'h014A},
        {3'h1, 2'h2, 3'h7, 16'h3C5A, 8'h04, 16'h3C5A},
        {3'h1, 2'h3, 3'h1, 16'hFF3C, 8'h00, 16'h0078},
        {3'h2, 2'h3, 3'h1, 16'h0455, 8'h02, 16'hFC55},
        {3'h2, 2'h1, 3'h2, 16'hBB81, 8'h03, 16'h0081},
        {3'h2, 2'h2, 3'h5, 16'h77C3, 8'h00, 16'hC300}};
    logic sys_clk, reset, reg_wr, reg_rd, frame_sync, aux_req_valid, aux_rsp_valid, aux_rsp_parity;
    logic ram_we, bad_par, mute, fault_exp;
    logic [15:0] reg_addr, aux_rsp_data, ans_word, ram_wdata;
    logic [7:0] reg_wdata, reg_rdata, ans_delay, rv, hi, rq, ram_addr;
    logic [2:0] pair_mod_bit, pair_pulse_out, pair_analog_en, aux_req_cmd, aux_req_item, pulse_seen;
    logic [1:0] aux_req_phase;
    int fails, n_checks, n_req, nr0, i, k;
    logic [7:0] wq_addr[$];
    logic [15:0] wq_data[$];

    iscp_top #(.PULSE_DIV(2), .RSP_TIMEOUT(8)) iscp_top_i (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync(frame_sync),
        .pair_mod_bit(pair_mod_bit), .pair_pulse_out(pair_pulse_out), .pair_analog_en(pair_analog_en),
        .aux_req_valid(aux_req_valid), .aux_req_phase(aux_req_phase), .aux_req_cmd(aux_req_cmd),
        .aux_req_item(aux_req_item), .aux_rsp_valid(aux_rsp_valid), .aux_rsp_data(aux_rsp_data),
        .aux_rsp_parity(aux_rsp_parity), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata));
    iscp_sensor_model iscp_sensor_model_i (
        .sys_clk(sys_clk), .reset(reset), .answer_word(ans_word), .answer_delay(ans_delay),
        .bad_parity(bad_par), .mute(mute), .aux_req_valid(aux_req_valid),
        .aux_rsp_valid(aux_rsp_valid), .aux_rsp_data(aux_rsp_data), .aux_rsp_parity(aux_rsp_parity));

    // Clock, 20 ns period
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Record requests, pulses and RAM writes
    always @(posedge sys_clk) begin
        pulse_seen <= reset ? 3'b000 : pulse_seen | pair_pulse_out;
        if (aux_req_valid === 1'b1) begin
            n_req++;
            rq <= {aux_req_cmd, aux_req_phase, aux_req_item};
        end
        if (ram_we === 1'b1) begin
            wq_addr.push_back(ram_addr);
            wq_data.push_back(ram_wdata);
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Poll until the command bits clear, bounded
    task automatic wait_done(input logic [1:0] ph);
        k = 0;
        do begin
            rd(16'h00FC, rv);
            k++;
        end while (rv[4:2] !== 3'b000 && k < 40);
        chk("request register", {8'h00, 1'b0, fault_exp, 4'h0, ph}, {8'h00, rv});
    endtask : wait_done

    task automatic xfer(input logic [47:0] t);
        wr(16'h270A, {1'b0, (t[44:43] == 2'h2) ? t[42:40] : ~t[42:40],
            1'b0, (t[44:43] == 2'h1) ? t[42:40] : ~t[42:40]});
        wr(16'h2709, {5'b00111, (t[44:43] == 2'h3) ? t[42:40] : ~t[42:40]});
        ans_word <= t[39:24];
        ans_delay <= t[23:16];
        wr(16'h00FC, {3'b010, t[47:45], t[44:43]});
        wait_done(t[44:43]);
        chk("request fields", {8'h00, t[47:40]}, {8'h00, rq});
        rd(16'h2602, hi);
        rd(16'h2603, rv);
        chk("read buffer", t[15:0], {hi, rv});
    endtask : xfer

    task automatic frame(input int nw, input logic [7:0] a1);
        frame_sync <= 1'b1;
        @(posedge sys_clk);
        frame_sync <= 1'b0;
        repeat (20) @(posedge sys_clk);
        wq_addr.delete();
        wq_data.delete();
        frame_sync <= 1'b1;
        @(posedge sys_clk);
        frame_sync <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("ram write count", 16'(nw), 16'(wq_addr.size()));
        for (i = 0; i < wq_addr.size(); i++) begin
            chk("ram address", {8'h00, (i == 1) ? a1 : 8'(i)}, {8'h00, wq_addr[i]});
            chk("ram data", {15'h0, i != 0}, {15'h0, wq_data[i] != 16'h0000});
        end
    endtask : frame

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // Watchdog
    initial begin
        #400000;
        fails++;
        final_report();
    end

    // Test sequence
    initial begin
        {reset, reg_wr, reg_rd, bad_par, mute, fault_exp} = 6'b100000;
        frame_sync = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        ans_word = 16'h0000;
        ans_delay = 8'h00;
        pair_mod_bit = 3'b110;
        fails = 0;
        n_checks = 0;
        n_req = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        for (int j = 0; j < 6; j++) begin
            rd(RA[j], rv);
            chk("reset value", 16'h0000, {8'h00, rv});
        end
        chk("analog mode", 16'h0007, {13'h0, pair_analog_en});
        chk("no pulses", 16'h0000, {13'h0, pulse_seen});
        $display("test reset done");
        wr(16'h270A, 8'hFF);
        rd(16'h270A, rv);
        chk("select pairs a b", 16'h0077, {8'h00, rv});
        wr(16'h2709, 8'hFA);
        rd(16'h2709, rv);
        chk("select pair c", 16'h00FA, {8'h00, rv});
        repeat (8) @(posedge sys_clk);
        chk("link mode", 16'h0000, {13'h0, pair_analog_en});
        chk("pulses run", 16'h0007, {13'h0, pulse_seen});
        $display("test registers done");
        for (int j = 0; j < 6; j++) begin
            xfer(TBL[j]);
        end
        $display("test reads done");
        nr0 = n_req;
        ans_word <= 16'h0012;
        ans_delay <= 8'h04;
        wr(16'h00FC, 8'h09);
        wr(16'h00FC, 8'h0A);
        rd(16'h00FC, rv);
        chk("request while busy", 16'h0009, {8'h00, rv});
        wait_done(2'h1);
        for (int c = 0; c < 3; c++) begin
            wr(16'h00FC, (c == 0) ? 8'h01 : (c == 1) ? 8'h15 : 8'h04);
            rd(16'h00FC, rv);
            chk("refused command", 16'h0000, {13'h0, rv[4:2]});
        end
        wr(16'h2602, 8'h55);
        rd(16'h2602, hi);
        rd(16'h2603, rv);
        chk("single request", 16'h0001, 16'(n_req - nr0));
        chk("buffer after busy", 16'h0012, {hi, rv});
        $display("test refusals done");
        bad_par <= 1'b1;
        fault_exp = 1'b1;
        xfer({3'h2, 2'h1, 3'h2, 16'h0033, 8'h00, 16'h0033});
        bad_par <= 1'b0;
        xfer({3'h2, 2'h1, 3'h3, 16'h0044, 8'h01, 16'h0044});
        wr(16'h00FC, 8'h00);
        fault_exp = 1'b0;
        wait_done(2'h1);
        mute <= 1'b1;
        fault_exp = 1'b1;
        wr(16'h00FC, 8'h09);
        wait_done(2'h1);
        mute <= 1'b0;
        wr(16'h00FC, 8'h00);
        $display("test parity done");
        frame(3, 8'h01);
        wr(16'h2709, 8'h28);
        frame(2, 8'h02);
        chk("pair b analog", 16'h0002, {13'h0, pair_analog_en});
        wr(16'h00FC, 8'h4A);
        rd(16'h00FC, rv);
        chk("disabled pair request", 16'h0000, {13'h0, rv[4:2]});
        $display("test frames done");
        final_report();
    end
endmodule : tb

`default_nettype wire
